// File: src/tpc_error_counters.sv
// T1 receive performance error counters with an APB register slave
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// saturating accumulator with a held copy refreshed on every tick
module tpc_sat_acc
#(
   parameter int WIDTH = 12
)
(
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             tick_i,
   input  wire logic [1:0]       inc_i,
   output logic      [WIDTH-1:0] count_o
);

   logic [WIDTH-1:0] acc_ff;
   logic [WIDTH-1:0] nxt_acc;
   logic [WIDTH-1:0] held_ff;
   logic [WIDTH-1:0] nxt_held;
   logic [WIDTH:0]   sum;

   // next accumulator and held values
   always_comb
   begin
      sum      = {1'b0, acc_ff} + {{(WIDTH-1){1'b0}}, inc_i};
      // R2: stop at maximum
      nxt_acc  = sum[WIDTH] ? {WIDTH{1'b1}} : sum[WIDTH-1:0];
      nxt_held = held_ff;
      if (tick_i)
      begin
         // R1: refresh on boundary
         nxt_held = acc_ff;
         // R15: clear, keep tick events
         nxt_acc  = WIDTH'(inc_i);
      end
   end

   // registers only
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         acc_ff  <= '0;
         held_ff <= '0;
      end
      else
      begin
         acc_ff  <= nxt_acc;
         held_ff <= nxt_held;
      end
   end

   assign count_o = held_ff; // software sees only the held copy

endmodule // tpc_sat_acc

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: all counters refresh every one-second boundary
// R2: counters saturate at maximum, never wrap
// R3: host reads counters before next boundary
// R4: 16-bit line count split high/low bytes
// R5: line counts violations plus optional zero runs
// R6: valid B8ZS codewords not counted when selected
// R7: line counter keeps counting during sync loss
// R8: ESF path counter counts CRC6 errors
// R9: D4 path counts Ft, optionally Fs errors
// R10: path counter halts during sync loss
// R11: path count in 0x25 low nibble, 0x26
// R12: mode one counts multiframes out of sync
// R13: mode zero counts pattern errors, sync-gated
// R14: multiframe count in 0x25 high nibble, 0x27
// R15: accumulator copied and cleared each boundary
module tpc_error_counters
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              REF_CLK_I,
   input  wire logic              RST_B_I,
   // apb slave
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [ADDR_W-1:0] PADDR_I,
   input  wire logic [31:0]       PWDATA_I,
   input  wire logic [3:0]        PSTRB_I,
   output logic      [31:0]       PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   // events from the receive decoder and synchronizer
   input  wire logic              ONE_SECOND_TICK_I,
   input  wire logic              RX_BIT_VALID_I,
   input  wire logic              RX_BIT_ZERO_I,
   input  wire logic              BIPOLAR_VIOLATION_I,
   input  wire logic              B8ZS_CODEWORD_I,
   input  wire logic              RECEIVE_SYNC_LOSS_I,
   input  wire logic              CRC6_ERROR_I,
   input  wire logic              FT_ERROR_I,
   input  wire logic              FS_ERROR_I,
   input  wire logic              FPS_ERROR_I,
   input  wire logic              RX_MULTIFRAME_I
);

   import tpc_pkg::*;

   logic [CTRL_W-1:0] ctrl_ff;
   logic [CTRL_W-1:0] nxt_ctrl;
   logic [31:0]       rdata_ff;
   logic [31:0]       nxt_rdata;
   logic [RUN_W-1:0]  run_ff;
   logic [RUN_W-1:0]  nxt_run;
   logic              oos_seen_ff;
   logic              nxt_oos_seen;
   logic              excessive_zero_count_enable;
   logic              receive_b8zs_select;
   logic              esf_framing_select;
   logic              fs_error_count_enable;
   logic              multiframe_mode_select;
   logic [RUN_W-1:0]  run_limit;
   logic              zero_event;
   logic              bpv_event;
   logic [1:0]        line_inc;
   logic [1:0]        path_inc;
   logic [1:0]        mf_inc;
   logic [LINE_W-1:0] line_count;
   logic [PATH_W-1:0] path_count;
   logic [MF_W-1:0]   mf_count;
   logic [5:0]        reg_idx;
   logic              aligned;
   logic              hit;
   logic              wr_ok;
   logic              setup_rd;
   logic              access;
   ////////////////////////////////////////////////////////////////////////////
   // control fields
   assign excessive_zero_count_enable = ctrl_ff[CTRL_EXZ_POS];
   assign receive_b8zs_select         = ctrl_ff[CTRL_B8ZS_POS];
   assign esf_framing_select          = ctrl_ff[CTRL_ESF_POS];
   assign fs_error_count_enable       = ctrl_ff[CTRL_FS_POS];
   assign multiframe_mode_select      = ctrl_ff[CTRL_MF_POS];
   ////////////////////////////////////////////////////////////////////////////
   // zero run tracking; one event per run, not per extra zero,
   // so a long dead line costs one count rather than flooding the counter
   always_comb
   begin
      // R5: run length from B8ZS select
      run_limit  = receive_b8zs_select ? ZERO_RUN_SHORT : ZERO_RUN_LONG;
      nxt_run    = run_ff;
      zero_event = 1'b0;
      if (RX_BIT_VALID_I)
      begin
         if (!RX_BIT_ZERO_I)
         begin
            nxt_run = '0;
         end
         else if (run_ff < run_limit)
         begin
            nxt_run    = run_ff + 5'h01;
            zero_event = (nxt_run == run_limit);
         end
      end
   end
   // run counter register
   always_ff @(posedge REF_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         run_ff <= '0;
      end
      else
      begin
         run_ff <= nxt_run;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // line counter increment; no sync-loss gating here
   always_comb
   begin
      // R6: skip substitution codewords
      bpv_event = BIPOLAR_VIOLATION_I &
                  !(receive_b8zs_select & B8ZS_CODEWORD_I);
      // R5: violations plus zero runs
      // R7: always enabled
      line_inc  = {1'b0, bpv_event} +
                  {1'b0, zero_event & excessive_zero_count_enable};
   end
   ////////////////////////////////////////////////////////////////////////////
   // path counter increment
   always_comb
   begin
      path_inc = 2'h0;
      // R10: halt on sync loss
      if (!RECEIVE_SYNC_LOSS_I)
      begin
         if (esf_framing_select)
         begin
            // R8: crc6 errors only
            path_inc = {1'b0, CRC6_ERROR_I};
         end
         else
         begin
            // R9: Ft plus optional Fs
            path_inc = {1'b0, FT_ERROR_I} +
                       {1'b0, FS_ERROR_I & fs_error_count_enable};
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // multiframe counter; a loss seen anywhere in the multiframe marks it,
   // so a short dropout between boundaries is not missed
   always_comb
   begin
      nxt_oos_seen = oos_seen_ff | RECEIVE_SYNC_LOSS_I;
      mf_inc       = 2'h0;
      if (RX_MULTIFRAME_I)
      begin
         nxt_oos_seen = RECEIVE_SYNC_LOSS_I;
      end
      if (multiframe_mode_select)
      begin
         // R12: out-of-sync multiframes
         mf_inc = {1'b0, RX_MULTIFRAME_I &
                   (oos_seen_ff | RECEIVE_SYNC_LOSS_I)};
      end
      else if (!RECEIVE_SYNC_LOSS_I)
      begin
         // R13: pattern errors, sync-gated
         mf_inc = {1'b0, esf_framing_select ? FPS_ERROR_I : FT_ERROR_I};
      end
   end
   // out-of-sync marker register
   always_ff @(posedge REF_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         oos_seen_ff <= 1'b0;
      end
      else
      begin
         oos_seen_ff <= nxt_oos_seen;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // R1: refresh on tick
   tpc_sat_acc #(.WIDTH(LINE_W)) u_line_acc
   (
      .clk_i   (REF_CLK_I),
      .rst_b_i (RST_B_I),
      .tick_i  (ONE_SECOND_TICK_I),
      .inc_i   (line_inc),
      .count_o (line_count)
   );
   // R2: saturate, never wrap
   tpc_sat_acc #(.WIDTH(PATH_W)) u_path_acc
   (
      .clk_i   (REF_CLK_I),
      .rst_b_i (RST_B_I),
      .tick_i  (ONE_SECOND_TICK_I),
      .inc_i   (path_inc),
      .count_o (path_count)
   );
   // R15: copy and clear
   tpc_sat_acc #(.WIDTH(MF_W)) u_mf_acc
   (
      .clk_i   (REF_CLK_I),
      .rst_b_i (RST_B_I),
      .tick_i  (ONE_SECOND_TICK_I),
      .inc_i   (mf_inc),
      .count_o (mf_count)
   );
   ////////////////////////////////////////////////////////////////////////////
   // apb decode; zero wait states, address held through access phase
   assign reg_idx  = PADDR_I[7:2];
   assign aligned  = (PADDR_I[1:0] == 2'h0) && ((32'(PADDR_I) >> 8) == 32'h0);
   assign hit      = aligned &&
                     ((reg_idx == IDX_LINE_HIGH) || (reg_idx == IDX_LINE_LOW) ||
                      (reg_idx == IDX_PATH_HIGH) || (reg_idx == IDX_PATH_LOW) ||
                      (reg_idx == IDX_MF_LOW)    || (reg_idx == IDX_CONTROL));
   assign wr_ok    = aligned && (reg_idx == IDX_CONTROL);
   assign setup_rd = PSEL_I & !PENABLE_I & !PWRITE_I;
   assign access   = PSEL_I & PENABLE_I;

   assign PREADY_O  = 1'b1;
   // counters are read-only: writes to them are flagged, not stored
   assign PSLVERR_O = access & (PWRITE_I ? !wr_ok : !hit);
   assign PRDATA_O  = rdata_ff;
   ////////////////////////////////////////////////////////////////////////////
   // read data captured in setup phase, control written in access phase
   always_comb
   begin
      nxt_rdata = rdata_ff;
      nxt_ctrl  = ctrl_ff;
      if (setup_rd)
      begin
         nxt_rdata = RDATA_RESET;
         if (aligned)
         begin
            unique case (reg_idx)
               // R4: line count bytes
               IDX_LINE_HIGH: nxt_rdata[7:0] = line_count[15:8];
               IDX_LINE_LOW:  nxt_rdata[7:0] = line_count[7:0];
               // R11: path nibble, R14: multiframe nibble
               IDX_PATH_HIGH: nxt_rdata[7:0] = {mf_count[11:8],
                                                path_count[11:8]};
               // R11: path low byte
               IDX_PATH_LOW:  nxt_rdata[7:0] = path_count[7:0];
               // R14: multiframe low byte
               IDX_MF_LOW:    nxt_rdata[7:0] = mf_count[7:0];
               IDX_CONTROL:   nxt_rdata[CTRL_W-1:0] = ctrl_ff;
               default:       nxt_rdata = RDATA_RESET;
            endcase
         end
      end
      if (access && PWRITE_I && wr_ok && PSTRB_I[0])
      begin
         nxt_ctrl = PWDATA_I[CTRL_W-1:0];
      end
   end
   // bus registers
   always_ff @(posedge REF_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         rdata_ff <= RDATA_RESET;
         ctrl_ff  <= CTRL_RESET;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
         ctrl_ff  <= nxt_ctrl;
      end
   end

endmodule // tpc_error_counters

`default_nettype wire

// File: src/tpc_pkg.sv
// shared constants for the T1 performance error counter block
package tpc_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_LINE_HIGH = 6'h23;
   localparam logic [5:0] IDX_LINE_LOW  = 6'h24;
   localparam logic [5:0] IDX_PATH_HIGH = 6'h25; // shared with multiframe high
   localparam logic [5:0] IDX_PATH_LOW  = 6'h26;
   localparam logic [5:0] IDX_MF_LOW    = 6'h27;
   localparam logic [5:0] IDX_CONTROL   = 6'h30;

   // control register field positions
   localparam int CTRL_EXZ_POS  = 0; // excessive_zero_count_enable
   localparam int CTRL_B8ZS_POS = 1; // receive_b8zs_select
   localparam int CTRL_ESF_POS  = 2; // esf_framing_select
   localparam int CTRL_FS_POS   = 3; // fs_error_count_enable
   localparam int CTRL_MF_POS   = 4; // multiframe_mode_select
   localparam int CTRL_W        = 5;

   // reset values
   localparam logic [CTRL_W-1:0] CTRL_RESET  = 5'h00;
   localparam logic [31:0]       RDATA_RESET = 32'h0000_0000;

   // counter widths
   localparam int LINE_W = 16;
   localparam int PATH_W = 12;
   localparam int MF_W   = 12;

   // zero run lengths that count as one excessive-zero event
   localparam int          RUN_W         = 5;
   localparam logic [RUN_W-1:0] ZERO_RUN_LONG  = 5'h10;
   localparam logic [RUN_W-1:0] ZERO_RUN_SHORT = 5'h08;

endpackage : tpc_pkg

// File: verification/tpc_error_counters_checker.sv
// bound checker with a shadow model of the three counters
`timescale 1ns/1ps
`default_nettype none
module tpc_error_counters_checker
   import tpc_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic              REF_CLK_I,
   input wire logic              RST_B_I,
   input wire logic              PSEL_I,
   input wire logic              PENABLE_I,
   input wire logic              PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0]       PWDATA_I,
   input wire logic [3:0]        PSTRB_I,
   input wire logic [31:0]       PRDATA_O,
   input wire logic              PREADY_O,
   input wire logic              PSLVERR_O,
   input wire logic              ONE_SECOND_TICK_I,
   input wire logic              RX_BIT_VALID_I,
   input wire logic              RX_BIT_ZERO_I,
   input wire logic              BIPOLAR_VIOLATION_I,
   input wire logic              B8ZS_CODEWORD_I,
   input wire logic              RECEIVE_SYNC_LOSS_I,
   input wire logic              CRC6_ERROR_I,
   input wire logic              FT_ERROR_I,
   input wire logic              FS_ERROR_I,
   input wire logic              FPS_ERROR_I,
   input wire logic              RX_MULTIFRAME_I
);
   logic [4:0]  ctrl_ff;
   logic [4:0]  run_ff;
   logic        seen_ff;
   logic [15:0] la_ff, lh_ff, pa_ff, ph_ff, ma_ff, mh_ff;
   ////////////////////////////////////////
   // decoded bus phase and per-cycle increments
   wire logic [5:0] ix = 6'(PADDR_I >> 2);
   wire logic acc = PSEL_I & PENABLE_I;
   wire logic rd = acc & !PWRITE_I;
   wire logic los = RECEIVE_SYNC_LOSS_I;
   wire logic esf = ctrl_ff[CTRL_ESF_POS];
   wire logic b8 = ctrl_ff[CTRL_B8ZS_POS];
   wire logic [4:0] thr = b8 ? ZERO_RUN_SHORT : ZERO_RUN_LONG;
   wire logic zev = ctrl_ff[CTRL_EXZ_POS] & RX_BIT_VALID_I & RX_BIT_ZERO_I
                    & (run_ff == thr - 5'h01);
   wire logic [1:0] linc = 2'(BIPOLAR_VIOLATION_I & !(b8 & B8ZS_CODEWORD_I))
                           + 2'(zev);
   wire logic [1:0] pinc = los ? 2'h0 : esf ? 2'(CRC6_ERROR_I) : 2'(FT_ERROR_I)
                           + 2'(FS_ERROR_I & ctrl_ff[CTRL_FS_POS]);
   wire logic [1:0] minc = ctrl_ff[CTRL_MF_POS] ?
                           2'(RX_MULTIFRAME_I & (seen_ff | los)) :
                           los ? 2'h0 : 2'(esf ? FPS_ERROR_I : FT_ERROR_I);
   wire logic unm = !(ix inside {[IDX_LINE_HIGH:IDX_MF_LOW], IDX_CONTROL})
                    | (PADDR_I[1:0] != 2'b00);
   // saturating add, so the model never wraps either
   function automatic logic [15:0] sat(input logic [15:0] a,
      input logic [1:0] i, input logic [16:0] mx);
      logic [16:0] s;
      s = {1'b0, a} + 17'(i);
      return (s > mx) ? mx[15:0] : s[15:0];
   endfunction
   // shadow registers; run length is capped so it cannot wrap to a new event
   always_ff @(posedge REF_CLK_I or negedge RST_B_I)
      if (!RST_B_I)
         {ctrl_ff, run_ff, seen_ff, la_ff, lh_ff, pa_ff, ph_ff, ma_ff, mh_ff}
            <= '0;
      else
      begin
         if (acc & PWRITE_I & PSTRB_I[0] & (ix == IDX_CONTROL)
             & (PADDR_I[1:0] == 2'b00))
            ctrl_ff <= PWDATA_I[4:0];
         if (RX_BIT_VALID_I)
            run_ff <= !RX_BIT_ZERO_I ? 5'h00 : (run_ff >= thr) ? run_ff
                      : run_ff + 5'h01;
         seen_ff <= RX_MULTIFRAME_I ? los : (seen_ff | los);
         la_ff <= ONE_SECOND_TICK_I ? 16'(linc) : sat(la_ff, linc, 17'hFFFF);
         pa_ff <= ONE_SECOND_TICK_I ? 16'(pinc) : sat(pa_ff, pinc, 17'h0FFF);
         ma_ff <= ONE_SECOND_TICK_I ? 16'(minc) : sat(ma_ff, minc, 17'h0FFF);
         if (ONE_SECOND_TICK_I)
            {lh_ff, ph_ff, mh_ff} <= {la_ff, pa_ff, ma_ff};
      end
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_B_I);
   property p_line_high;
      rd & (ix == IDX_LINE_HIGH) |-> PRDATA_O == {24'h0, $past(lh_ff[15:8])};
   endproperty
   a_line_high: assert property (p_line_high) else $error("line high bad");
   property p_line_low;
      rd & (ix == IDX_LINE_LOW) |-> PRDATA_O == {24'h0, $past(lh_ff[7:0])};
   endproperty
   a_line_low: assert property (p_line_low) else $error("line low bad");
   property p_shared;
      rd & (ix == IDX_PATH_HIGH) |->
         PRDATA_O == {24'h0, $past(mh_ff[11:8]), $past(ph_ff[11:8])};
   endproperty
   a_shared: assert property (p_shared) else $error("shared byte bad");
   property p_path_low;
      rd & (ix == IDX_PATH_LOW) |-> PRDATA_O == {24'h0, $past(ph_ff[7:0])};
   endproperty
   a_path_low: assert property (p_path_low) else $error("path low bad");
   property p_mf_low;
      rd & (ix == IDX_MF_LOW) |-> PRDATA_O == {24'h0, $past(mh_ff[7:0])};
   endproperty
   a_mf_low: assert property (p_mf_low) else $error("mf low bad");
   property p_ro;
      acc & PWRITE_I & (ix inside {[IDX_LINE_HIGH:IDX_MF_LOW]}) |-> PSLVERR_O;
   endproperty
   a_ro: assert property (p_ro) else $error("counter write accepted");
   property p_stand;
      !$past(PSEL_I & !PENABLE_I & !PWRITE_I) |-> $stable(PRDATA_O);
   endproperty
   a_stand: assert property (p_stand) else $error("read data moved");
   property p_unmapped;
      rd & unm |-> PSLVERR_O && (PRDATA_O == 32'h0) && PREADY_O;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped bad");
   c_tick: cover property (ONE_SECOND_TICK_I & los);
   c_err: cover property (acc & PSLVERR_O);
   c_full: cover property (rd & (ix == IDX_PATH_LOW) & (PRDATA_O == 32'hFF));
endmodule // tpc_error_counters_checker

bind tpc_error_counters tpc_error_counters_checker #(.ADDR_W(ADDR_W))
   tpc_error_counters_checker_inst (.REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
   .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
   .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .ONE_SECOND_TICK_I(ONE_SECOND_TICK_I), .RX_BIT_VALID_I(RX_BIT_VALID_I),
   .RX_BIT_ZERO_I(RX_BIT_ZERO_I), .BIPOLAR_VIOLATION_I(BIPOLAR_VIOLATION_I),
   .B8ZS_CODEWORD_I(B8ZS_CODEWORD_I),
   .RECEIVE_SYNC_LOSS_I(RECEIVE_SYNC_LOSS_I), .CRC6_ERROR_I(CRC6_ERROR_I),
   .FT_ERROR_I(FT_ERROR_I), .FS_ERROR_I(FS_ERROR_I),
   .FPS_ERROR_I(FPS_ERROR_I), .RX_MULTIFRAME_I(RX_MULTIFRAME_I));
`default_nettype wire

// File: verification/tpc_testbench.sv
// self-checking bench for the T1 performance error counters
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tpc_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  padr = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic        tick = 1'b0;
   logic        los = 1'b0;
   logic [8:0]  evq = 9'h000; // zero,valid,mf,fps,fs,ft,crc,codeword,bpv
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rd;
   logic        er;
   int          error_cnt = 0;
   int          n_tests = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   tpc_error_counters #(.ADDR_W(8)) tpc_error_counters_inst (
      .REF_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PSTRB_I(4'hF),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .ONE_SECOND_TICK_I(tick), .RX_BIT_VALID_I(evq[7]),
      .RX_BIT_ZERO_I(evq[8]), .BIPOLAR_VIOLATION_I(evq[0]),
      .B8ZS_CODEWORD_I(evq[1]), .RECEIVE_SYNC_LOSS_I(los),
      .CRC6_ERROR_I(evq[2]), .FT_ERROR_I(evq[3]), .FS_ERROR_I(evq[4]),
      .FPS_ERROR_I(evq[5]), .RX_MULTIFRAME_I(evq[6]));
   ////////////////////////////////////////
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one transfer; each starts after an edge so psel never toggles twice
   task automatic apb(input logic w, input logic [5:0] ix,
      input logic [31:0] wd);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      padr <= {ix, 2'b00};
      pwd <= wd;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 40);
      if (pready !== 1'b1)
      begin
         error_cnt++;
         report_and_stop();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic setc(input logic [4:0] c);
      apb(1'b1, IDX_CONTROL, {27'h0, c});
   endtask
   // hold an event pattern for n cycles
   task automatic ev(input logic [8:0] v, input int n);
      repeat (n)
      begin
         @(posedge clk);
         evq <= v;
      end
      @(posedge clk);
      evq <= 9'h000;
   endtask
   // a run of zeros closed by a one
   task automatic zrun(input int n);
      ev(9'h180, n);
      ev(9'h080, 1);
   endtask
   // boundary pulse, then all five count bytes
   task automatic cnt(input logic [15:0] l, input logic [11:0] p,
      input logic [11:0] m, input logic [8:0] tv);
      logic [7:0] ex [5];
      ex = '{l[15:8], l[7:0], {m[11:8], p[11:8]}, p[7:0], m[7:0]};
      @(posedge clk);
      tick <= 1'b1;
      evq <= tv;
      @(posedge clk);
      tick <= 1'b0;
      evq <= 9'h000;
      // read all bytes before next tick
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, IDX_LINE_HIGH + 6'(i), 32'h0);
         chk(rd, {24'h0, ex[i]});
         chk(32'(er), 32'h0);
      end
      $display("test done at %0t", $time);
   endtask
   // main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      apb(1'b0, IDX_CONTROL, 32'h0);
      chk(rd, 32'h0);
      setc(5'h1F);
      apb(1'b0, IDX_CONTROL, 32'h0);
      chk(rd, 32'h1F);
      apb(1'b1, IDX_LINE_LOW, 32'hFF);
      chk(32'(er), 32'h1);
      apb(1'b0, 6'h3F, 32'h0);
      chk(rd, 32'h0);
      chk(32'(er), 32'h1);
      cnt(16'h0, 12'h0, 12'h0, 9'h0);
      setc(5'h00);
      ev(9'h001, 5);
      ev(9'h003, 3);
      ev(9'h008, 2);
      ev(9'h010, 3);
      cnt(16'd8, 12'd2, 12'd2, 9'h0);
      setc(5'h0A);
      ev(9'h003, 4);
      ev(9'h001, 1);
      ev(9'h018, 2);
      zrun(20);
      cnt(16'd1, 12'd4, 12'd2, 9'h0);
      setc(5'h01);
      zrun(16);
      zrun(15);
      zrun(40);
      cnt(16'd2, 12'd0, 12'd0, 9'h0);
      setc(5'h03);
      zrun(8);
      zrun(7);
      zrun(17);
      cnt(16'd2, 12'd0, 12'd0, 9'h0);
      setc(5'h0C);
      ev(9'h004, 2);
      ev(9'h008, 3);
      ev(9'h010, 3);
      ev(9'h020, 3);
      cnt(16'd0, 12'd2, 12'd3, 9'h0);
      setc(5'h00);
      los <= 1'b1;
      ev(9'h001, 3);
      ev(9'h008, 4);
      cnt(16'd3, 12'd0, 12'd0, 9'h0);
      setc(5'h10);
      ev(9'h040, 3);
      ev(9'h008, 2);
      cnt(16'd0, 12'd0, 12'd3, 9'h0);
      los <= 1'b0;
      setc(5'h04);
      ev(9'h025, 65540);
      cnt(16'hFFFF, 12'hFFF, 12'hFFF, 9'h0);
      cnt(16'd0, 12'd0, 12'd0, 9'h001);
      cnt(16'd1, 12'd0, 12'd0, 9'h0);
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
